// [thermo_regs.svh]
// Register offsets, field positions, reset values and timing counts.
// Assumes a byte-addressed Avalon-MM slave with 32-bit data words.
`ifndef THERMO_REGS_SVH
`define THERMO_REGS_SVH

`define OFS_CTRL 6'h00
`define OFS_HIGH_TRIP 6'h04
`define OFS_LOW_TRIP 6'h08
`define OFS_TEMP 6'h0C
`define OFS_COUNT 6'h10
`define OFS_BASE 6'h14
`define OFS_SLOPE 6'h18
`define OFS_STEP 6'h1C
`define OFS_CMD 6'h20
`define OFS_IRQ_STAT 6'h24
`define OFS_IRQ_MASK 6'h28

`define CTRL_POL 0
`define CTRL_HIGH_FLAG 1
`define CTRL_LOW_FLAG 2
`define CTRL_DONE 3

`define IRQ_DONE 0
`define IRQ_HIGH 1
`define IRQ_LOW 2

`define TEMP_MIN 9'h192
`define TEMP_MAX 9'h0FA
`define RST_HIGH_TRIP 9'h050
`define RST_LOW_TRIP 9'h03C
`define RST_BASE 16'h0100
`define RST_SLOPE 16'h0040
`define RST_STEP 16'h0001
`define RST_POL 1'h1

`define CONV_MAX_MS 500
`define CLK_HZ 40000000

`endif

// [thermo_pkg.sv]
// Types shared by the thermometer core and its helper modules.
// Assumes thermo_regs.svh supplies all numeric constants.
package thermo_pkg;
    typedef enum logic [1:0] {
        CMD_NONE,
        CMD_TEMP,
        CMD_COUNT,
        CMD_SLOPE
    } read_cmd_e;

    typedef enum logic {
        MEAS_IDLE,
        MEAS_GATE
    } meas_state_e;

    typedef struct packed {
        logic [8:0] temp;
        logic [15:0] count;
    } conv_result_s;

    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } edge_s;
endpackage

// [sync_edge.sv]
// Two-flop synchroniser for a pin, with rise and fall detection.
// Assumes the pin is slow against sys_clk_i, at least four cycles a level.
`timescale 1ns/100ps
module sync_edge (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Pin and its edges.
    input wire logic pin_i,
    output thermo_pkg::edge_s edges_o
);
    import thermo_pkg::*;

    logic [2:0] sync_ff;
    logic [2:0] nxt_sync;

    // Only the second and third stages feed the edge logic.
    always_comb begin
        nxt_sync = {sync_ff[1:0], pin_i};
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_ff <= 3'h0;
        end else begin
            sync_ff <= nxt_sync;
        end
    end

    // One assignment drives the whole struct: level, rise, fall.
    assign edges_o = {sync_ff[1], sync_ff[1] & ~sync_ff[2],
                      ~sync_ff[1] & sync_ff[2]};
endmodule // sync_edge

// [msb_shifter.sv]
// Open-drain serial shifter sending a 16-bit word most significant first.
// Assumes the serial clock edges arrive already synchronised.
`timescale 1ns/100ps
module msb_shifter (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Word to send.
    input wire logic load_i,
    input wire logic [15:0] word_i,
    // Serial clock edges and data pin.
    input thermo_pkg::edge_s sclk_i,
    output logic data_o,
    output logic data_oe_n_o
);
    import thermo_pkg::*;

    logic [15:0] shift_ff;
    logic [15:0] nxt_shift;
    logic [4:0] left_ff;
    logic [4:0] nxt_left;

    always_comb begin
        nxt_shift = shift_ff;
        nxt_left = left_ff;
        if (load_i) begin
            nxt_shift = word_i;
            nxt_left = 5'h10;
        end else if (sclk_i.fall && left_ff != 5'h0) begin
            nxt_shift = {shift_ff[14:0], 1'b0}; // R5
            nxt_left = 5'(left_ff - 5'h1);
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_ff <= 16'h0;
            left_ff <= 5'h0;
        end else begin
            shift_ff <= nxt_shift;
            left_ff <= nxt_left;
        end
    end

    // A one bit releases the line, so only zeros are driven.
    assign data_o = 1'b0;
    assign data_oe_n_o = ~(left_ff != 5'h0 && !shift_ff[15]);

    msb_first_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        load_i |=> data_oe_n_o == $past(word_i[15])) // R5
        else $error("Shifter did not start with the top bit.");
endmodule // msb_shifter

// [thermo_core.sv]
// Temperature measurement and thermostat core with Avalon-MM registers.
// Assumes gate and count oscillators and serial clock are asynchronous pins.
// Behaviour
// R1 - Gate start presets counter and temperature
// R2 - Counter expiry increments temperature one step
// R3 - Reload counter from slope accumulator, repeat
// R4 - Temperature read gives 9-bit half-degree value
// R5 - Serial data goes most significant first
// R6 - Byte one whole degrees, byte two half
// R7 - Temperature spans lowest to highest value
// R8 - Counter read gives remainder at gate end
// R9 - Slope command copies accumulator to count
// R10 - Master may compute finer resolution itself
// R11 - Thermostat re-evaluated after each conversion
// R12 - Output on at high, off below low
// R13 - Active output level is selectable
// R14 - Conversion finishes within maximum conversion time
// R15 - Polarity one active high, zero low
// R16 - Sticky high flag, cleared by writing zero
// R17 - Sticky low flag, cleared by writing zero
// R18 - Output holds between conversions
// R19 - Readout changes only when conversion completes
`include "thermo_regs.svh"
`timescale 1ns/100ps
module thermo_core #(
    parameter int CONV_CYCLES = `CONV_MAX_MS * (`CLK_HZ / 1000)
) (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Avalon-MM slave.
    input wire logic [5:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    // Oscillator pins.
    input wire logic gate_osc_i,
    input wire logic count_osc_i,
    // Serial read-out pins.
    input wire logic scl_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // Thermostat and interrupt.
    output logic tout_o,
    output logic irq_o
);
    import thermo_pkg::*;

    function automatic logic at_least(input logic [8:0] a,
                                      input logic [8:0] b);
        return $signed(a) >= $signed(b);
    endfunction

    function automatic logic [15:0] temp_word(input logic [8:0] t);
        return {t[8:1], t[0], 7'h00};
    endfunction

    edge_s gate_e;
    edge_s osc_e;
    edge_s scl_e;

    sync_edge gate_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .pin_i(gate_osc_i),
        .edges_o(gate_e)
    );

    sync_edge osc_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .pin_i(count_osc_i),
        .edges_o(osc_e)
    );

    sync_edge scl_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .pin_i(scl_i),
        .edges_o(scl_e)
    );

    // Bus register group.
    logic ack_ff, nxt_ack;
    logic [31:0] rdata_ff, nxt_rdata;
    logic pol_ff, nxt_pol;
    logic [8:0] high_trip_ff, nxt_high_trip;
    logic [8:0] low_trip_ff, nxt_low_trip;
    logic [15:0] base_ff, nxt_base;
    logic [15:0] slope_ff, nxt_slope;
    logic [15:0] step_ff, nxt_step;
    logic [2:0] mask_ff, nxt_mask;
    read_cmd_e cmd_ff, nxt_cmd;
    logic wr_go;

    // Measurement group.
    meas_state_e state_ff, nxt_state;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [8:0] temp_ff, nxt_temp;
    logic [15:0] acc_ff, nxt_acc;
    logic [24:0] timer_ff, nxt_timer;
    conv_result_s res_ff, nxt_res;
    logic [15:0] count_reg_ff, nxt_count_reg;
    logic done_ff, nxt_done;
    logic conv_end;
    logic expire;

    // Thermostat and status group.
    logic hyst_ff, nxt_hyst;
    logic high_flag_ff, nxt_high_flag;
    logic low_flag_ff, nxt_low_flag;
    logic [2:0] irq_stat_ff, nxt_irq_stat;
    logic [2:0] irq_set;

    // A single wait state lets read data come from a flip-flop.
    assign waitrequest_o = (read_i | write_i) & ~ack_ff;
    assign wr_go = write_i & ack_ff;
    assign readdata_o = rdata_ff;

    always_comb begin
        nxt_ack = (read_i | write_i) & ~ack_ff;
        nxt_rdata = rdata_ff;
        nxt_pol = pol_ff;
        nxt_high_trip = high_trip_ff;
        nxt_low_trip = low_trip_ff;
        nxt_base = base_ff;
        nxt_slope = slope_ff;
        nxt_step = step_ff;
        nxt_mask = mask_ff;
        nxt_cmd = CMD_NONE;
        if (read_i && !ack_ff) begin
            unique case (address_i)
                `OFS_CTRL: nxt_rdata = {28'h0, done_ff, low_flag_ff,
                                        high_flag_ff, pol_ff};
                `OFS_HIGH_TRIP: nxt_rdata = {23'h0, high_trip_ff};
                `OFS_LOW_TRIP: nxt_rdata = {23'h0, low_trip_ff};
                `OFS_TEMP: nxt_rdata = {16'h0, temp_word(res_ff.temp)}; // R4
                `OFS_COUNT: nxt_rdata = {16'h0, count_reg_ff}; // R8
                `OFS_BASE: nxt_rdata = {16'h0, base_ff};
                `OFS_SLOPE: nxt_rdata = {16'h0, slope_ff};
                `OFS_STEP: nxt_rdata = {16'h0, step_ff};
                `OFS_IRQ_STAT: nxt_rdata = {29'h0, irq_stat_ff};
                `OFS_IRQ_MASK: nxt_rdata = {29'h0, mask_ff};
                default: nxt_rdata = 32'h0;
            endcase
        end
        if (wr_go) begin
            unique case (address_i)
                `OFS_CTRL: nxt_pol = writedata_i[`CTRL_POL]; // R13
                `OFS_HIGH_TRIP: nxt_high_trip = writedata_i[8:0];
                `OFS_LOW_TRIP: nxt_low_trip = writedata_i[8:0];
                `OFS_BASE: nxt_base = writedata_i[15:0];
                `OFS_SLOPE: nxt_slope = writedata_i[15:0];
                `OFS_STEP: nxt_step = writedata_i[15:0];
                `OFS_CMD: nxt_cmd = read_cmd_e'(writedata_i[1:0]);
                `OFS_IRQ_MASK: nxt_mask = writedata_i[2:0];
                default: nxt_cmd = CMD_NONE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0;
            pol_ff <= `RST_POL;
            high_trip_ff <= `RST_HIGH_TRIP;
            low_trip_ff <= `RST_LOW_TRIP;
            base_ff <= `RST_BASE;
            slope_ff <= `RST_SLOPE;
            step_ff <= `RST_STEP;
            mask_ff <= 3'h0;
            cmd_ff <= CMD_NONE;
        end else begin
            ack_ff <= nxt_ack;
            rdata_ff <= nxt_rdata;
            pol_ff <= nxt_pol;
            high_trip_ff <= nxt_high_trip;
            low_trip_ff <= nxt_low_trip;
            base_ff <= nxt_base;
            slope_ff <= nxt_slope;
            step_ff <= nxt_step;
            mask_ff <= nxt_mask;
            cmd_ff <= nxt_cmd;
        end
    end

    // The timeout closes a gate that never falls, bounding conversion time.
    assign conv_end = (state_ff == MEAS_GATE) &&
        (gate_e.fall || timer_ff == 25'(CONV_CYCLES - 1)); // R14
    assign expire = (state_ff == MEAS_GATE) && !conv_end && osc_e.rise &&
        cnt_ff <= 16'h0001;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_temp = temp_ff;
        nxt_acc = acc_ff;
        nxt_timer = timer_ff;
        nxt_res = res_ff;
        nxt_count_reg = count_reg_ff;
        nxt_done = done_ff;
        unique case (state_ff)
            MEAS_IDLE: begin
                if (gate_e.rise) begin
                    nxt_cnt = base_ff; // R1
                    nxt_temp = `TEMP_MIN; // R1
                    nxt_acc = slope_ff;
                    nxt_timer = 25'h0;
                    nxt_done = 1'b0;
                    nxt_state = MEAS_GATE;
                end
            end
            MEAS_GATE: begin
                nxt_timer = conv_end ? timer_ff : 25'(timer_ff + 25'h1);
                if (conv_end) begin
                    nxt_res.temp = temp_ff; // R19
                    nxt_res.count = cnt_ff;
                    nxt_count_reg = cnt_ff; // R8
                    nxt_done = 1'b1;
                    nxt_state = MEAS_IDLE;
                end else if (expire) begin
                    if (temp_ff != `TEMP_MAX) begin
                        nxt_temp = 9'(temp_ff + 9'h1); // R2 R7
                    end
                    nxt_cnt = acc_ff; // R3
                    nxt_acc = 16'(acc_ff + step_ff); // R3
                end else if (osc_e.rise) begin
                    nxt_cnt = 16'(cnt_ff - 16'h1);
                end
            end
        endcase
        if (cmd_ff == CMD_SLOPE && !conv_end) begin
            nxt_count_reg = acc_ff; // R9
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= MEAS_IDLE;
            cnt_ff <= 16'h0;
            temp_ff <= `TEMP_MIN;
            acc_ff <= 16'h0;
            timer_ff <= 25'h0;
            res_ff <= {`TEMP_MIN, 16'h0};
            count_reg_ff <= 16'h0;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            temp_ff <= nxt_temp;
            acc_ff <= nxt_acc;
            timer_ff <= nxt_timer;
            res_ff <= nxt_res;
            count_reg_ff <= nxt_count_reg;
            done_ff <= nxt_done;
        end
    end

    // Flags and status bits: a set in the clearing cycle wins.
    always_comb begin
        nxt_hyst = hyst_ff; // R18
        nxt_high_flag = high_flag_ff;
        nxt_low_flag = low_flag_ff;
        irq_set = 3'h0;
        if (wr_go && address_i == `OFS_CTRL) begin
            nxt_high_flag = high_flag_ff & writedata_i[`CTRL_HIGH_FLAG];
            nxt_low_flag = low_flag_ff & writedata_i[`CTRL_LOW_FLAG];
        end
        if (conv_end) begin
            irq_set[`IRQ_DONE] = 1'b1;
            if (at_least(temp_ff, high_trip_ff)) begin
                nxt_hyst = 1'b1; // R11 R12
                nxt_high_flag = 1'b1; // R16
                irq_set[`IRQ_HIGH] = 1'b1;
            end else if (!at_least(temp_ff, low_trip_ff)) begin
                nxt_hyst = 1'b0; // R12
            end
            if (at_least(low_trip_ff, temp_ff)) begin
                nxt_low_flag = 1'b1; // R17
                irq_set[`IRQ_LOW] = 1'b1;
            end
        end
        nxt_irq_stat = irq_stat_ff;
        if (wr_go && address_i == `OFS_IRQ_STAT) begin
            nxt_irq_stat = irq_stat_ff & ~writedata_i[2:0];
        end
        nxt_irq_stat = nxt_irq_stat | irq_set;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hyst_ff <= 1'b0;
            high_flag_ff <= 1'b0;
            low_flag_ff <= 1'b0;
            irq_stat_ff <= 3'h0;
        end else begin
            hyst_ff <= nxt_hyst;
            high_flag_ff <= nxt_high_flag;
            low_flag_ff <= nxt_low_flag;
            irq_stat_ff <= nxt_irq_stat;
        end
    end

    assign tout_o = pol_ff ? hyst_ff : ~hyst_ff; // R13 R15
    assign irq_o = |(irq_stat_ff & mask_ff);

    // Serial read-out; the slope command only copies, it sends nothing.
    msb_shifter readout (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .load_i(cmd_ff == CMD_TEMP || cmd_ff == CMD_COUNT),
        .word_i(cmd_ff == CMD_TEMP ? temp_word(res_ff.temp) // R6
                                   : count_reg_ff),
        .sclk_i(scl_e),
        .data_o(sda_o),
        .data_oe_n_o(sda_oe_n_o)
    );

    preset_load_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_ff == MEAS_IDLE && gate_e.rise |=>
        temp_ff == `TEMP_MIN && cnt_ff == $past(base_ff)) // R1
        else $error("Gate start did not preset counter and temperature.");
    temp_step_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        expire && temp_ff != `TEMP_MAX |=>
        temp_ff == 9'($past(temp_ff) + 9'h1)) // R2
        else $error("Counter expiry did not step the temperature.");
    slope_reload_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        expire |=> cnt_ff == $past(acc_ff) && state_ff == MEAS_GATE) // R3
        else $error("Counter not reloaded from the slope accumulator.");
    temp_range_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        at_least(temp_ff, `TEMP_MIN) && at_least(`TEMP_MAX, temp_ff)) // R7
        else $error("Temperature left its range.");
    temp_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        read_i && !waitrequest_o && address_i == `OFS_TEMP |->
        readdata_o[6:0] == 7'h0 && readdata_o[15:7] == res_ff.temp) // R4 R6
        else $error("Temperature read has the wrong layout.");
    count_keep_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        conv_end |=> count_reg_ff == $past(cnt_ff)) // R8
        else $error("Remaining count not captured at gate end.");
    slope_copy_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        cmd_ff == CMD_SLOPE && !conv_end |=>
        count_reg_ff == $past(acc_ff)) // R9
        else $error("Slope command did not copy the accumulator.");
    trip_high_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        conv_end && at_least(temp_ff, high_trip_ff) |=>
        tout_o == pol_ff && high_flag_ff) // R11 R12 R15 R16
        else $error("High trip not signalled after conversion.");
    trip_low_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        conv_end && at_least(low_trip_ff, temp_ff) |=> low_flag_ff) // R17
        else $error("Low flag not set after conversion.");
    tout_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !conv_end && !wr_go |=> $stable(tout_o) && $stable(res_ff)) // R18 R19
        else $error("Output or readout changed between conversions.");
    conv_time_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        timer_ff < 25'(CONV_CYCLES)) // R14
        else $error("Conversion ran past its maximum time.");
endmodule // thermo_core

// [twowire_master.sv]
// Two-wire master model that clocks a 16-bit word out of the core.
// Assumes the data line is pulled up whenever the core releases it.
`timescale 1ns/100ps
module twowire_master #(
    parameter int HALF_NS = 400
) (
    // Serial clock out, data line in.
    output logic scl_o,
    input wire logic sda_i
);
    // The clock stands high between frames, as an idle bus does.
    initial begin
        scl_o = 1'b1;
    end

    // The caller may refine the reading from count and slope.
    task automatic read_word(output logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            #(HALF_NS) w[i] = sda_i;
            scl_o = 1'b0;
            #(HALF_NS) scl_o = 1'b1;
        end
    endtask
endmodule // twowire_master

// [thermometer_thermostat_core_test.sv]
// Self-checking bench for the thermometer core and its register bus.
// Assumes the core's package, register header and a two-wire master model.
`include "thermo_regs.svh"
`timescale 1ns/100ps
module thermometer_thermostat_core_test;
    import thermo_pkg::*;
    localparam int CONV = 4000;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, read_i = 1'b0, write_i = 1'b0;
    logic gate_osc_i = 1'b0, count_osc_i = 1'b0, scl, sda;
    logic [5:0] address_i = 6'h00;
    logic [31:0] writedata_i = 32'h0000_0000, readdata_o, r, x;
    logic waitrequest_o, sda_o, sda_oe_n_o, tout_o, irq_o;
    logic [8:0] hi, lo;
    logic [15:0] w;
    logic output_polarity, hyst, hf, lf;
    conv_result_s e;
    int mismatches = 0, checks = 0, b, s, n, stp = 0;

    // Open-drain line with a pull-up.
    assign sda = sda_oe_n_o ? 1'b1 : sda_o;

    thermo_core #(.CONV_CYCLES(CONV)) dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
        .gate_osc_i(gate_osc_i), .count_osc_i(count_osc_i), .scl_i(scl),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .tout_o(tout_o),
        .irq_o(irq_o));
    twowire_master mst (.scl_o(scl), .sda_i(sda));

    initial begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #2_000_000;
        mismatches++;
        conclude();
    end

    task automatic chk(input string nm, input logic [31:0] v,
                       input logic [31:0] xp);
        checks++;
        if (v !== xp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, xp, v);
        end
    endtask

    // Waits on the slave's own answer; only the watchdog ends a hang.
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk_i);
        address_i <= a;
        writedata_i <= d;
        read_i <= !wr;
        write_i <= wr;
        @(posedge sys_clk_i);
        while (waitrequest_o !== 1'b0) begin
            @(posedge sys_clk_i);
        end
        r = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] xp,
                      input string nm);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, r, xp);
    endtask

    function automatic logic [31:0] tword(logic [8:0] t);
        return {16'h0000, t[8:1], t[0], 7'h00};
    endfunction

    function automatic logic tout_exp();
        return output_polarity ? hyst : ~hyst;
    endfunction

    // Walks the count edges one at a time; stp is the accumulator step.
    function automatic conv_result_s predict(int bb, int ss, int nn);
        conv_result_s p;
        int t, c, a;
        t = -110;
        c = bb;
        a = ss;
        for (int i = 0; i < nn; i++) begin
            if (c > 1) begin
                c--;
            end else begin
                t = (t < 250) ? t + 1 : 250;
                c = a;
                a += stp;
            end
        end
        p.temp = 9'(t);
        p.count = 16'(c);
        return p;
    endfunction

    // One gate period; the count pin toggles every 100 ns on clock edges.
    task automatic conv(input int bb, input int ss, input int nn);
        bus(1'b1, `OFS_BASE, 32'(bb));
        bus(1'b1, `OFS_SLOPE, 32'(ss));
        @(posedge sys_clk_i) gate_osc_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        repeat (nn) begin
            @(posedge sys_clk_i) count_osc_i <= 1'b1;
            repeat (4) @(posedge sys_clk_i);
            count_osc_i <= 1'b0;
            repeat (3) @(posedge sys_clk_i);
        end
        rd(`OFS_TEMP, tword(e.temp), "temp held");
        chk("tout held", tout_o, tout_exp());
        @(posedge sys_clk_i) gate_osc_i <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
        e = predict(bb, ss, nn);
        if ($signed(e.temp) >= $signed(hi)) begin
            hyst = 1'b1;
        end else if ($signed(e.temp) < $signed(lo)) begin
            hyst = 1'b0;
        end
        hf |= $signed(e.temp) >= $signed(hi);
        lf |= $signed(e.temp) <= $signed(lo);
        rd(`OFS_TEMP, tword(e.temp), "temp");
        rd(`OFS_COUNT, 32'(e.count), "count");
        rd(`OFS_CTRL, {28'h0, 1'b1, lf, hf, output_polarity}, "ctrl");
        chk("tout", tout_o, tout_exp());
    endtask

    initial begin
        void'($urandom(32'h9378));
        hi = `RST_HIGH_TRIP;
        lo = `RST_LOW_TRIP;
        output_polarity = `RST_POL;
        {hyst, hf, lf} = 3'h0;
        e = predict(1, 1, 0);
        e.count = 16'h0000;
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rd(`OFS_CTRL, 32'h0000_0001, "ctrl reset");
        rd(`OFS_TEMP, 32'h0000_C900, "temp reset");
        rd(`OFS_COUNT, 32'h0000_0000, "count reset");
        bus(1'b1, 6'h3C, 32'hFFFF_FFFF);
        rd(6'h3C, 32'h0000_0000, "unmapped");
        chk("tout reset", tout_o, 1'b0);
        bus(1'b1, `OFS_STEP, 32'h0000_0000);
        $display("test reset done");
        // Slope one steps the reading on every edge until it saturates at the maximum.
        conv(1, 1, 400);
        for (int i = 0; i < 5; i++) begin
            conv(1, 1, i == 0 ? 180 : i == 1 ? 170 : i == 2 ? 169 :
                 i == 3 ? 185 : 190);
        end
        $display("test thermostat done");
        bus(1'b1, `OFS_CTRL, 32'h0000_0000);
        {output_polarity, hf, lf} = 3'h0;
        repeat (2) @(negedge sys_clk_i);
        chk("tout low", tout_o, tout_exp());
        rd(`OFS_CTRL, 32'h0000_0008, "flags cleared");
        $display("test polarity done");
        // A gate held open past the limit still ends the conversion.
        @(posedge sys_clk_i) gate_osc_i <= 1'b1;
        repeat (10) @(posedge sys_clk_i);
        bus(1'b0, `OFS_CTRL, 32'h0000_0000);
        chk("busy", r[3], 1'b0);
        repeat (CONV) @(posedge sys_clk_i);
        bus(1'b0, `OFS_CTRL, 32'h0000_0000);
        chk("done", r[3], 1'b1);
        rd(`OFS_TEMP, 32'h0000_C900, "temp limit");
        @(posedge sys_clk_i) gate_osc_i <= 1'b0;
        e = predict(1, 1, 0);
        hyst = 1'b0;
        lf = 1'b1;
        $display("test limit done");
        bus(1'b1, `OFS_IRQ_STAT, 32'h0000_0007);
        bus(1'b1, `OFS_IRQ_MASK, 32'h0000_0001);
        repeat (2) @(negedge sys_clk_i);
        chk("irq clear", irq_o, 1'b0);
        conv(1, 1, 5);
        chk("irq set", irq_o, 1'b1);
        bus(1'b1, `OFS_IRQ_MASK, 32'h0000_0000);
        repeat (2) @(negedge sys_clk_i);
        chk("irq masked", irq_o, 1'b0);
        bus(1'b1, `OFS_IRQ_MASK, 32'h0000_0001);
        bus(1'b1, `OFS_IRQ_STAT, 32'h0000_0001);
        repeat (2) @(negedge sys_clk_i);
        chk("irq w1c", irq_o, 1'b0);
        $display("test interrupt done");
        // A growing accumulator stretches each later half-degree step by one count.
        stp = 1;
        bus(1'b1, `OFS_STEP, 32'h0000_0001);
        conv(2, 2, 9);
        bus(1'b1, `OFS_CMD, 32'h0000_0003);
        rd(`OFS_COUNT, 32'h0000_0005, "grown slope");
        stp = 0;
        bus(1'b1, `OFS_STEP, 32'h0000_0000);
        $display("test step done");
        for (int i = 0; i < 16; i++) begin
            b = $urandom_range(30, 5);
            s = $urandom_range(12, 2);
            n = $urandom_range(120, 0);
            hi = 9'($urandom_range(60, 0) - 110);
            lo = hi - 9'($urandom_range(20, 0));
            x = $urandom_range(7, 0);
            bus(1'b1, `OFS_HIGH_TRIP, 32'(hi));
            bus(1'b1, `OFS_LOW_TRIP, 32'(lo));
            bus(1'b1, `OFS_CTRL, x);
            output_polarity = x[0];
            hf &= x[1];
            lf &= x[2];
            rd(`OFS_HIGH_TRIP, 32'(hi), "high trip");
            conv(b, s, n);
            for (int c = 1; c <= 2; c++) begin
                bus(1'b1, `OFS_CMD, 32'(c));
                repeat (3) @(posedge sys_clk_i);
                mst.read_word(w);
                chk("serial", w, c == 1 ? tword(e.temp) : e.count);
                chk("sda idle", sda, 1'b1);
            end
            bus(1'b1, `OFS_CMD, 32'h0000_0003);
            rd(`OFS_COUNT, 32'(s), "slope");
        end
        $display("test random done");
        conclude();
    end
endmodule // thermometer_thermostat_core_test
